/* verilog/modem_host_port_init_control.sv */
// Contract
// - After power-up or any reset the strap pin is an input and is sampled to pick the mode.
// - A low strap selects RS-485, a high or open strap selects RS-232C.
// - Once the mode is sampled the strap pin turns into an output, so it must not be tied hard.
// - In RS-485 mode the former strap pin is the transmit enable of the outside line driver.
// - While the load-defaults input is low the default parameter set is loaded.
// - A low shutdown input puts the port into shutdown, which acts as a hardware reset.
// - After power-up about 220 ms of initialisation pass before serial input is accepted.
// - After shutdown returns high about 75 ms pass before serial input is accepted.
// - On the serial data lines a mark is high and a space is low.
`timescale 1ns/1ps
module modem_host_port_init_control #(
    parameter int PWRUP_CYC = modem_init_pkg::PWRUP_WAIT_CYC,
    parameter int RESET_CYC = modem_init_pkg::RESET_WAIT_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic shut_n,
    input wire logic def_param_n,
    input wire logic line_driver_enable_strap_in,
    output logic line_driver_enable_strap_out,
    output logic line_driver_enable_strap_oe_n,
    input wire logic txd_pin,
    output logic rxd_pin,
    input wire logic tx_drive_req,
    input wire logic rx_line_data,
    output logic tx_line_data,
    output logic mode_rs485,
    output logic load_defaults,
    output logic core_reset,
    output logic host_ready
);
    localparam int W = modem_init_pkg::WAIT_W;

    // Both waits must fit the counter and be at least one cycle
    if (PWRUP_CYC < 1 || PWRUP_CYC >= 2 ** W) begin : g_bad_pwrup
        $error("PWRUP_CYC out of range for the wait counter");
    end
    if (RESET_CYC < 1 || RESET_CYC >= 2 ** W) begin : g_bad_reset
        $error("RESET_CYC out of range for the wait counter");
    end

    modem_init_pkg::port_state_e state;
    logic shut_s1, shut_s2;
    logic def_s1, def_s2;
    logic strap_s1, strap_s2;
    logic txd_s1, txd_s2;
    logic [2:0] settle;
    logic after_shut;
    logic sampled_mode;

    wait_if #(.W(W)) wt ();

    init_wait_timer #(.W(W)) u_timer (
        .clk(clk),
        .resetn(resetn),
        .w(wt)
    );

    // Pin inputs pass two flops before any logic reads them
    always_ff @(posedge clk) begin
        shut_s1 <= shut_n;
        shut_s2 <= shut_s1;
        def_s1 <= def_param_n;
        def_s2 <= def_s1;
        strap_s1 <= line_driver_enable_strap_in;
        strap_s2 <= strap_s1;
        txd_s1 <= txd_pin;
        txd_s2 <= txd_s1;
    end

    // Wait length depends on why we are initialising
    assign wt.limit = after_shut ? W'(RESET_CYC) : W'(PWRUP_CYC);
    assign wt.clear = (state != modem_init_pkg::ST_INIT);

    // Port sequencer: sample, wait, run; shutdown overrides all
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= modem_init_pkg::ST_SAMPLE;
            after_shut <= 1'b0;
            settle <= '0;
            sampled_mode <= modem_init_pkg::MODE_RESET;
        end else if (!shut_s2 && state != modem_init_pkg::ST_SHUT) begin
            state <= modem_init_pkg::ST_SHUT;
        end else begin
            case (state)
                modem_init_pkg::ST_SAMPLE: begin
                    // Settle lets the sync chain flush stale pin levels
                    if (settle == 3'(modem_init_pkg::STRAP_SETTLE_CYC - 1)) begin
                        sampled_mode <= !strap_s2;
                        state <= modem_init_pkg::ST_INIT;
                    end else begin
                        settle <= settle + 3'd1;
                    end
                end
                modem_init_pkg::ST_INIT: begin
                    if (wt.expired) begin
                        state <= modem_init_pkg::ST_RUN;
                    end
                end
                modem_init_pkg::ST_RUN: begin
                    state <= modem_init_pkg::ST_RUN;
                end
                modem_init_pkg::ST_SHUT: begin
                    // Release re-samples the strap, then the short wait
                    if (shut_s2) begin
                        state <= modem_init_pkg::ST_SAMPLE;
                        after_shut <= 1'b1;
                        settle <= '0;
                    end
                end
                default: begin
                    state <= modem_init_pkg::ST_SAMPLE;
                end
            endcase
        end
    end

    // Mode output follows the latched sample only; held until re-sample
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_rs485 <= modem_init_pkg::MODE_RESET;
        end else begin
            mode_rs485 <= sampled_mode;
        end
    end

    // Strap pin: input while sampling or shut down, then an output
    // Shutdown is a hardware reset, so the pin is released as at power-up
    always_ff @(posedge clk) begin
        if (!resetn) begin
            line_driver_enable_strap_oe_n <= 1'b1;
            line_driver_enable_strap_out <= 1'b0;
        end else if ((state == modem_init_pkg::ST_SAMPLE)
            || (state == modem_init_pkg::ST_SHUT)) begin
            line_driver_enable_strap_oe_n <= 1'b1;
            line_driver_enable_strap_out <= 1'b0;
        end else begin
            line_driver_enable_strap_oe_n <= 1'b0;
            // Driver enabled only while running in RS-485 mode
            line_driver_enable_strap_out <= sampled_mode && tx_drive_req
                && (state == modem_init_pkg::ST_RUN);
        end
    end

    // Control outputs toward the modem core
    always_ff @(posedge clk) begin
        if (!resetn) begin
            load_defaults <= 1'b0;
            core_reset <= 1'b1;
            host_ready <= 1'b0;
        end else begin
            load_defaults <= !def_s2;
            core_reset <= (state == modem_init_pkg::ST_SAMPLE)
                || (state == modem_init_pkg::ST_SHUT);
            host_ready <= (state == modem_init_pkg::ST_RUN);
        end
    end

    // Data lines pass straight, mark high; idle at mark when not running
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxd_pin <= modem_init_pkg::MARK_LEVEL;
            tx_line_data <= modem_init_pkg::MARK_LEVEL;
        end else if (state == modem_init_pkg::ST_RUN) begin
            rxd_pin <= rx_line_data;
            tx_line_data <= txd_s2;
        end else begin
            rxd_pin <= modem_init_pkg::MARK_LEVEL;
            tx_line_data <= modem_init_pkg::MARK_LEVEL;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_shut_low;
        !shut_s2 ##1 !shut_s2;
    endsequence

    sequence s_core_held;
        core_reset [*2];
    endsequence

    chk_strap_as_input: assert property (
        (state == modem_init_pkg::ST_SAMPLE) |=> line_driver_enable_strap_oe_n)
        else $error("strap driven while being sampled");
    chk_mode_from_strap: assert property (
        (state == modem_init_pkg::ST_SAMPLE && shut_s2
            && settle == 3'(modem_init_pkg::STRAP_SETTLE_CYC - 1))
        |=> ##1 (mode_rs485 == !$past(strap_s2, 2)))
        else $error("mode does not match sampled strap");
    chk_strap_turns_out: assert property (
        (state == modem_init_pkg::ST_INIT) |=> !line_driver_enable_strap_oe_n)
        else $error("strap not driven after sampling");
    chk_txen_follows: assert property (
        (state == modem_init_pkg::ST_RUN && shut_s2)
        |=> (line_driver_enable_strap_out == ($past(tx_drive_req) && $past(sampled_mode))))
        else $error("transmit enable does not follow request");
    chk_defaults_load: assert property (
        !def_s2 |=> load_defaults)
        else $error("defaults not loaded while input low");
    chk_shut_resets: assert property (
        s_shut_low |=> s_core_held)
        else $error("shutdown did not hold core in reset");
    chk_ready_after_wait: assert property (
        $rose(host_ready) |-> $past(wt.expired, 2) && $past(state, 2) == modem_init_pkg::ST_INIT)
        else $error("ready raised before the wait ended");
    chk_mode_holds: assert property (
        (state != modem_init_pkg::ST_SAMPLE && $past(state) != modem_init_pkg::ST_SAMPLE
            && $past(state, 2) != modem_init_pkg::ST_SAMPLE) |-> $stable(mode_rs485))
        else $error("mode changed without re-sampling");
    chk_mark_high: assert property (
        (state != modem_init_pkg::ST_RUN) |=> rxd_pin == modem_init_pkg::MARK_LEVEL)
        else $error("data line not idle at mark");
endmodule

/* verilog/modem_init_pkg.sv */
package modem_init_pkg;
    // Clock rate, in kilohertz, for converting waits into cycles
    localparam int CLK_KHZ = 125_000;
    // Initialisation waits, in milliseconds, and their cycle counts
    localparam int PWRUP_WAIT_MS = 220;
    localparam int RESET_WAIT_MS = 75;
    localparam int PWRUP_WAIT_CYC = PWRUP_WAIT_MS * CLK_KHZ;
    localparam int RESET_WAIT_CYC = RESET_WAIT_MS * CLK_KHZ;
    // Least shutdown low time the host must give, in microseconds
    localparam int SHUT_MIN_LOW_US = 1000;
    localparam int SHUT_MIN_LOW_CYC = (SHUT_MIN_LOW_US * CLK_KHZ + 999) / 1000;
    // Cycles the strap is watched as an input before it is latched
    localparam int STRAP_SETTLE_CYC = 4;
    // Width of the wait counter
    localparam int WAIT_W = 25;
    // Reset values of the pin side
    localparam logic MARK_LEVEL = 1'b1;
    localparam logic MODE_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_SAMPLE = 4'b0001,
        ST_INIT = 4'b0010,
        ST_RUN = 4'b0100,
        ST_SHUT = 4'b1000
    } port_state_e;
endpackage

/* verilog/wait_if.sv */
`timescale 1ns/1ps
interface wait_if #(parameter int W = 25);
    logic clear;
    logic [W-1:0] limit;
    logic expired;
    modport timer (input clear, input limit, output expired);
    modport ctrl (output clear, output limit, input expired);
endinterface

/* verilog/init_wait_timer.sv */
`timescale 1ns/1ps
module init_wait_timer #(
    parameter int W = 25
) (
    input wire logic clk,
    input wire logic resetn,
    wait_if.timer w
);
    logic [W-1:0] count;

    // A counter narrower than one bit cannot hold any wait
    if (W < 1) begin : g_bad_w
        $error("W must be at least 1 for the wait counter");
    end

    // Counts up from clear and parks at the limit
    always_ff @(posedge clk) begin
        if (!resetn || w.clear) begin
            count <= '0;
        end else if (count != w.limit) begin
            count <= count + 1'b1;
        end
    end

    assign w.expired = (count == w.limit);

    // Each counting cycle adds exactly one, so expiry takes exactly limit cycles
    chk_expiry_exact: assert property (@(posedge clk) disable iff (!resetn)
        (!w.clear && !w.expired) |=> (count == $past(count) + 1'b1))
        else $error("wait timer skipped or stalled a count");
endmodule

/* testbench/host_terminal_model.sv */
`timescale 1ns/1ps
module host_terminal_model (
    input wire logic shut_req,
    input wire logic strap_pull,
    input wire logic txd_bit,
    input wire logic def_req,
    input wire logic strap_out,
    input wire logic strap_oe_n,
    output logic shut_n,
    output logic def_param_n,
    output logic txd_pin,
    output logic strap_wire
);
    // Shutdown always driven to a firm level so a hung port can be reset
    assign shut_n = ~shut_req;
    // Load-defaults request, low active at the pin
    assign def_param_n = ~def_req;
    // Mark is a high level on the data line
    assign txd_pin = txd_bit;
    // Device drive wins; otherwise the strap resistor sets the level
    assign strap_wire = strap_oe_n ? strap_pull : strap_out;
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    // Short waits keep the run small; real counts are millions of cycles
    localparam int PW = 20;
    localparam int RW = 10;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic shut_req = 1'b0;
    logic strap_pull = 1'b0;
    logic txd_bit = 1'b1;
    logic def_req = 1'b0;
    logic tx_drive_req = 1'b0;
    logic rx_line_data = 1'b1;
    logic shut_n, def_param_n, txd_pin, strap_wire, strap_out, strap_oe_n;
    logic rxd_pin, tx_line_data, mode_rs485, load_defaults, core_reset, host_ready;
    logic rx_q, req_q;
    logic [2:0] txh, dfh;
    logic [7:0] lf = 8'h1E;
    int err_count = 0;
    int n_compared = 0;

    host_terminal_model u_host_terminal_model (.shut_req(shut_req), .strap_pull(strap_pull),
        .txd_bit(txd_bit), .def_req(def_req), .strap_out(strap_out), .strap_oe_n(strap_oe_n),
        .shut_n(shut_n), .def_param_n(def_param_n), .txd_pin(txd_pin), .strap_wire(strap_wire));

    modem_host_port_init_control #(.PWRUP_CYC(PW), .RESET_CYC(RW)) u_modem_host_port_init_control (
        .clk(clk), .resetn(resetn), .shut_n(shut_n), .def_param_n(def_param_n),
        .line_driver_enable_strap_in(strap_wire), .line_driver_enable_strap_out(strap_out),
        .line_driver_enable_strap_oe_n(strap_oe_n), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
        .tx_drive_req(tx_drive_req), .rx_line_data(rx_line_data), .tx_line_data(tx_line_data),
        .mode_rs485(mode_rs485), .load_defaults(load_defaults), .core_reset(core_reset),
        .host_ready(host_ready));

    // Free-running clock, 8 ns period
    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Low strap picks RS-485, high or open picks RS-232C
    function automatic logic mode_for_strap(input logic strap);
        return !strap;
    endfunction

    task automatic check(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            err_count++;
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait; too early is as wrong as too late
    task automatic wait_ready(input int lo);
        int n;
        n = 0;
        while (host_ready !== 1'b1 && n < lo + 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("ready_not_early", 1'b1, n >= lo);
        check("ready_in_time", 1'b1, n < lo + 20);
    endtask

    // Random traffic in run state; latencies follow the hand-over timing
    task automatic traffic(input logic m);
        for (int j = 0; j < 60; j++) begin
            @(posedge clk);
            #1;
            if (j > 2) begin
                check("tx_line_data", txh[2], tx_line_data);
                check("load_defaults", dfh[2], load_defaults);
            end
            if (j > 0) begin
                check("rxd_pin", rx_q, rxd_pin);
                check("strap_out", m & req_q, strap_out);
            end
            check("mode_rs485", m, mode_rs485);
            check("strap_oe_n", 1'b0, strap_oe_n);
            check("core_reset_run", 1'b0, core_reset);
            check("host_ready_run", 1'b1, host_ready);
            lf = lfsr_next(lf);
            rx_line_data = lf[0];
            tx_drive_req = lf[1];
            txd_bit = lf[2];
            def_req = (lf[7:6] == 2'b00);
            rx_q = lf[0];
            req_q = lf[1];
            txh = {txh[1:0], lf[2]};
            dfh = {dfh[1:0], def_req};
        end
    endtask

    // Main sequence: strap low, run, shutdown with strap high, run again
    initial begin
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        @(posedge clk);
        #1;
        check("strap_oe_n_sample", 1'b1, strap_oe_n);
        wait_ready(PW);
        traffic(mode_for_strap(strap_pull));
        @(posedge clk);
        #1;
        shut_req = 1'b1;
        strap_pull = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("core_reset", 1'b1, core_reset);
        check("host_ready", 1'b0, host_ready);
        check("rxd_pin_idle", 1'b1, rxd_pin);
        check("strap_oe_n_shut", 1'b1, strap_oe_n);
        // Low time scaled down; the device enforces no minimum
        repeat (200) @(posedge clk);
        #1 shut_req = 1'b0;
        wait_ready(RW);
        traffic(mode_for_strap(strap_pull));
        // Second power-up reset in mid-run with the strap pulled low again
        @(posedge clk);
        #1;
        resetn = 1'b0;
        strap_pull = 1'b0;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        @(posedge clk);
        #1;
        check("strap_oe_n_reset", 1'b1, strap_oe_n);
        check("core_reset_reset", 1'b1, core_reset);
        wait_ready(PW);
        traffic(mode_for_strap(strap_pull));
        final_report();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
